/* File: gpm_top.sv */
// gpm_top.sv: three gpio ports (analog-shared, timer-shared, debug-shared) on apb
// assumes zero-wait apb master on pclk; pads resolve dout/oe; pins are async
// Functional notes
// [R1] analog port: eight pins, own latch, per-pin direction bit
// [R2] software: digital input needs digital selection and input direction
// [R3] software: digital output needs digital selection and output direction
// [R4] software: analog input needs analog selection and input direction
// [R5] software allocates digital pins from bottom, analog from top
// [R6] reset makes every analog-port pin a digital input
// [R7] amp-input pin, analog, amp off: converted only when channel picks it
// [R8] amp-input pin, analog, amp on: amp input unless picked; picking prohibited
// [R9] amp-output pin, analog, amp on: carries amp output, converted when picked
// [R10] software never mixes digital with amp on, nor analog with output
// [R11] timer port: five pins, own latch, per-pin direction bit
// [R12] timer-port input pin gets pull-up when its pull-up bit set
// [R13] reset puts timer and debug ports in input mode
// [R14] software keeps timer, rtc and clock outputs off for port use
// [R15] debug port: two pins, latch, direction, pull-ups while input
// [R16] tool connected: no pull-ups on either debug pin
// [R17] tool connected: first debug pin is tool data, not a port
// [R18] single-line keeps second pin a port; two-line makes it tool clock
// [R19] port read returns pin for inputs, latch for outputs; write sets latch
// [R20] enabled alternate output on output pin combines with the latch
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "gpm_cfg.svh"
module gpm_top
  import gpm_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`GPM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog-shared port
  input wire logic [`GPM_AW-1:0] analog_pin_in,
  output gpm_apin_t analog_pin,
  output gpm_ana_t analog_route,
  output logic setting_prohibited,
  // timer-shared port
  input wire logic [`GPM_TW-1:0] timer_pin_in,
  input wire logic [`GPM_TW-1:0] timer_alt_out,
  input wire logic [`GPM_TW-1:0] timer_alt_en,
  output gpm_tpin_t timer_pin,
  output logic [`GPM_TW-1:0] timer_pullup_en,
  // debug-shared port and tool link
  input wire logic [`GPM_DW-1:0] debug_pin_in,
  input wire logic tool_connected,
  input wire logic tool_two_line,
  input wire logic tool_data_out,
  input wire logic tool_data_oe,
  input wire logic tool_clock_out,
  input wire logic tool_clock_oe,
  output gpm_dpin_t debug_pin,
  output logic [`GPM_DW-1:0] debug_pullup_en,
  output logic tool_data_in
);
  // direction bits: 1 = input, 0 = output
  logic [`GPM_AW-1:0] analog_port_latch;
  logic [`GPM_AW-1:0] analog_port_direction_reg;
  logic [`GPM_AW-1:0] analog_pin_config_reg;
  logic [2:0] opamp_enable_bit;
  logic [3:0] converter_channel_select;
  logic [`GPM_TW-1:0] timer_port_latch;
  logic [`GPM_TW-1:0] timer_port_direction_reg;
  logic [`GPM_TW-1:0] timer_port_pullup_reg;
  logic [`GPM_DW-1:0] debug_port_latch;
  logic [`GPM_DW-1:0] debug_port_direction_reg;
  logic [`GPM_DW-1:0] debug_port_pullup_reg;
  logic [`GPM_AW-1:0] analog_sync;
  logic [`GPM_TW-1:0] timer_sync;
  logic [`GPM_DW-1:0] debug_sync;
  logic staged;

  gpm_sync #(.WIDTH(`GPM_AW)) u_sync_a (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .d(analog_pin_in), .q(analog_sync));
  gpm_sync #(.WIDTH(`GPM_TW)) u_sync_t (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .d(timer_pin_in), .q(timer_sync));
  gpm_sync #(.WIDTH(`GPM_DW)) u_sync_d (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .d(debug_pin_in), .q(debug_sync));

  // apb decode; staged delays pready one enabled cycle so prdata is a flop
  wire wr_en = psel & penable & pwrite & pready;
  wire hit_alatch = paddr == `GPM_OFF_ALATCH;
  wire hit_adir = paddr == `GPM_OFF_ADIR;
  wire hit_acfg = paddr == `GPM_OFF_ACFG;
  wire hit_ampen = paddr == `GPM_OFF_AMPEN;
  wire hit_chsel = paddr == `GPM_OFF_CHSEL;
  wire hit_tlatch = paddr == `GPM_OFF_TLATCH;
  wire hit_tdir = paddr == `GPM_OFF_TDIR;
  wire hit_tpu = paddr == `GPM_OFF_TPU;
  wire hit_dlatch = paddr == `GPM_OFF_DLATCH;
  wire hit_ddir = paddr == `GPM_OFF_DDIR;
  wire hit_dpu = paddr == `GPM_OFF_DPU;
  wire hit_status = paddr == `GPM_OFF_STATUS;
  wire hit_any = hit_alatch | hit_adir | hit_acfg | hit_ampen | hit_chsel |
    hit_tlatch | hit_tdir | hit_tpu | hit_dlatch | hit_ddir | hit_dpu | hit_status;

  assign pready = clk_en & staged;

  // analog routing
  wire [`GPM_AW-1:0] amp_pin_en = {opamp_enable_bit[2], opamp_enable_bit[2],
    opamp_enable_bit[1], opamp_enable_bit[1], opamp_enable_bit[1],
    opamp_enable_bit[0], opamp_enable_bit[0], opamp_enable_bit[0]};
  wire [`GPM_AW-1:0] chan_pick = converter_channel_select[3] ? 8'h00 :
    (8'h01 << converter_channel_select[2:0]);
  wire [`GPM_AW-1:0] ana_in = analog_pin_config_reg & analog_port_direction_reg;
  wire [`GPM_AW-1:0] amp_in_on = `GPM_AMP_IN_MASK & amp_pin_en;
  // an amp input that is also picked would load the amp; it is not converted
  assign analog_route.convert = ana_in & chan_pick & ~amp_in_on; // [R7] [R9]
  assign analog_route.amp_in = ana_in & amp_in_on & ~chan_pick; // [R8]
  assign analog_route.amp_out = ana_in & `GPM_AMP_OUT_MASK & amp_pin_en; // [R9]
  assign setting_prohibited = |(~analog_pin_config_reg & amp_pin_en) |
    |(analog_pin_config_reg & ~analog_port_direction_reg) |
    |(ana_in & amp_in_on & chan_pick); // [R8]

  // pin drivers; analog selection cuts the digital driver off
  assign analog_pin.dout = analog_port_latch; // [R1]
  assign analog_pin.oe = ~analog_port_direction_reg & ~analog_pin_config_reg; // [R1]
  assign timer_pin.dout = timer_port_latch | (timer_alt_en & timer_alt_out); // [R20]
  assign timer_pin.oe = ~timer_port_direction_reg; // [R11]
  assign timer_pullup_en = timer_port_pullup_reg & timer_port_direction_reg; // [R12]
  wire tool_clk_own = tool_connected & tool_two_line;
  assign debug_pin.dout[`GPM_TOOL_DATA_BIT] = tool_connected ? tool_data_out :
    debug_port_latch[`GPM_TOOL_DATA_BIT]; // [R17]
  assign debug_pin.oe[`GPM_TOOL_DATA_BIT] = tool_connected ? tool_data_oe :
    ~debug_port_direction_reg[`GPM_TOOL_DATA_BIT]; // [R17]
  assign debug_pin.dout[`GPM_TOOL_CLK_BIT] = tool_clk_own ? tool_clock_out :
    debug_port_latch[`GPM_TOOL_CLK_BIT]; // [R18]
  assign debug_pin.oe[`GPM_TOOL_CLK_BIT] = tool_clk_own ? tool_clock_oe :
    ~debug_port_direction_reg[`GPM_TOOL_CLK_BIT]; // [R18]
  assign debug_pullup_en = tool_connected ? 2'h0 :
    debug_port_pullup_reg & debug_port_direction_reg; // [R15] [R16]
  assign tool_data_in = debug_sync[`GPM_TOOL_DATA_BIT];

  // read-back: inputs show the pin, outputs the latch; analog input pins read zero
  wire [`GPM_AW-1:0] a_read = (analog_port_direction_reg & ~analog_pin_config_reg &
    analog_sync) | (~analog_port_direction_reg & analog_port_latch); // [R19]
  wire [`GPM_TW-1:0] t_read = (timer_port_direction_reg & timer_sync) |
    (~timer_port_direction_reg & timer_port_latch); // [R19]
  wire [`GPM_DW-1:0] d_read = (debug_port_direction_reg & debug_sync) |
    (~debug_port_direction_reg & debug_port_latch); // [R19]
  wire [31:0] next_prdata =
    ({32{hit_alatch}} & {24'h0, a_read}) |
    ({32{hit_adir}} & {24'h0, analog_port_direction_reg}) |
    ({32{hit_acfg}} & {24'h0, analog_pin_config_reg}) |
    ({32{hit_ampen}} & {29'h0, opamp_enable_bit}) |
    ({32{hit_chsel}} & {28'h0, converter_channel_select}) |
    ({32{hit_tlatch}} & {27'h0, t_read}) |
    ({32{hit_tdir}} & {27'h0, timer_port_direction_reg}) |
    ({32{hit_tpu}} & {27'h0, timer_port_pullup_reg}) |
    ({32{hit_dlatch}} & {30'h0, d_read}) |
    ({32{hit_ddir}} & {30'h0, debug_port_direction_reg}) |
    ({32{hit_dpu}} & {30'h0, debug_port_pullup_reg}) |
    ({32{hit_status}} & {29'h0, tool_clk_own, tool_connected, setting_prohibited});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      staged <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      staged <= psel & ~(penable & staged);
      if (psel & ~staged) begin
        prdata <= pwrite ? 32'h0 : next_prdata;
        pslverr <= ~hit_any;
      end
    end
  end

  // latches accept every write, whatever the direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_port_latch <= `GPM_LATCH_RST_A;
      analog_port_direction_reg <= `GPM_DIR_RST_A; // [R6]
      analog_pin_config_reg <= `GPM_CFG_RST; // [R6]
      opamp_enable_bit <= `GPM_AMPEN_RST;
      converter_channel_select <= `GPM_CHSEL_RST;
    end else if (wr_en) begin
      if (hit_alatch) analog_port_latch <= pwdata[`GPM_AW-1:0]; // [R19]
      if (hit_adir) analog_port_direction_reg <= pwdata[`GPM_AW-1:0]; // [R1]
      if (hit_acfg) analog_pin_config_reg <= pwdata[`GPM_AW-1:0];
      if (hit_ampen) opamp_enable_bit <= pwdata[2:0];
      if (hit_chsel) converter_channel_select <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_port_latch <= `GPM_LATCH_RST_T;
      timer_port_direction_reg <= `GPM_DIR_RST_T; // [R13]
      timer_port_pullup_reg <= `GPM_PU_RST_T;
      debug_port_latch <= `GPM_LATCH_RST_D;
      debug_port_direction_reg <= `GPM_DIR_RST_D; // [R13]
      debug_port_pullup_reg <= `GPM_PU_RST_D;
    end else if (wr_en) begin
      if (hit_tlatch) timer_port_latch <= pwdata[`GPM_TW-1:0]; // [R19]
      if (hit_tdir) timer_port_direction_reg <= pwdata[`GPM_TW-1:0]; // [R11]
      if (hit_tpu) timer_port_pullup_reg <= pwdata[`GPM_TW-1:0];
      if (hit_dlatch) debug_port_latch <= pwdata[`GPM_DW-1:0]; // [R19]
      if (hit_ddir) debug_port_direction_reg <= pwdata[`GPM_DW-1:0]; // [R15]
      if (hit_dpu) debug_port_pullup_reg <= pwdata[`GPM_DW-1:0];
    end
  end

  // checks
  logic first_cyc;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) first_cyc <= 1'b1;
    else first_cyc <= 1'b0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reset_inputs_a: assert property (first_cyc |-> analog_pin.oe == 8'h00 && // [R6]
      timer_pin.oe == 5'h00 && (debug_pin.oe == 2'h0 || tool_connected) &&
      analog_route.convert == 8'h00 && analog_route.amp_out == 8'h00)
    else $error("ports not all inputs after reset");
  reset_dir_a: assert property (first_cyc |-> timer_port_direction_reg == 5'h1f && // [R13]
      debug_port_direction_reg == 2'h3)
    else $error("timer or debug port not input after reset");
  dir_write_a: assert property (wr_en && hit_adir |=> // [R1]
      analog_pin.oe == (~$past(pwdata[7:0]) & ~analog_pin_config_reg))
    else $error("analog direction write not reflected on enables");
  convert_pick_a: assert property (ana_in[2] && !amp_pin_en[2] && // [R7]
      converter_channel_select == 4'h2 |-> analog_route.convert == 8'h04)
    else $error("picked amp-input pin not converted");
  amp_in_pick_a: assert property (analog_route.amp_in != 8'h00 |-> // [R8]
      (analog_route.amp_in & chan_pick) == 8'h00 && !analog_route.amp_in[1])
    else $error("amp input routed while picked");
  amp_out_a: assert property (ana_in[4] && opamp_enable_bit[1] && // [R9]
      converter_channel_select == 4'h4 |-> analog_route.amp_out[4] &&
      analog_route.convert[4])
    else $error("amp output pin not routed or converted");
  timer_pullup_a: assert property (timer_pullup_en[3] |-> // [R12]
      timer_port_direction_reg[3] && !timer_pin.oe[3])
    else $error("pull-up on a timer pin driven as output");
  tool_pullup_a: assert property (tool_connected |-> debug_pullup_en == 2'h0) // [R16]
    else $error("pull-up on debug pin while tool connected");
  tool_data_a: assert property (tool_connected && !tool_two_line |-> // [R17] [R18]
      debug_pin.oe[0] == tool_data_oe &&
      debug_pin.dout[1] == debug_port_latch[1])
    else $error("debug pin ownership wrong in single-line mode");
  tool_clock_a: assert property (tool_connected && tool_two_line |-> // [R18]
      debug_pin.dout[1] == tool_clock_out && debug_pin.oe[1] == tool_clock_oe)
    else $error("tool clock pin not taken over");
  read_latch_a: assert property (psel && !staged && clk_en && !pwrite && // [R19]
      hit_tlatch && timer_port_direction_reg == 5'h00 |=>
      prdata[4:0] == $past(timer_port_latch))
    else $error("output pin read does not return latch");
  alt_out_a: assert property (timer_alt_en[0] && timer_alt_out[0] |-> // [R20]
      timer_pin.dout[0])
    else $error("alternate output not combined with latch");
  apb_ready_a: assert property (psel && !penable && clk_en |-> // [R19]
      !pready ##1 (pready || !clk_en))
    else $error("apb answer not one cycle after setup");

  // a picked amp input with its amp off is a plain converter channel
  convert_any_a: assert property ( // [R7]
      |(ana_in & chan_pick & `GPM_AMP_IN_MASK & ~amp_pin_en) |->
      analog_route.convert == (ana_in & chan_pick))
    else $error("picked analog pin with amp off not converted");

  convert_only_a: assert property ( // [R7] [R9]
      analog_route.convert != 8'h00 |->
      (analog_route.convert & ~chan_pick) == 8'h00)
    else $error("unpicked pin routed to converter");

  amp_out_pick_a: assert property ( // [R9]
      |(ana_in & `GPM_AMP_OUT_MASK & amp_pin_en & chan_pick) |->
      analog_route.convert == chan_pick && (analog_route.amp_out & chan_pick) == chan_pick)
    else $error("picked amp output not converted");

  amp_out_only_a: assert property ( // [R9]
      analog_route.amp_out != 8'h00 |->
      (analog_route.amp_out & ~(ana_in & `GPM_AMP_OUT_MASK)) == 8'h00)
    else $error("amp output routed on a wrong pin");

  amp_in_only_a: assert property ( // [R8]
      analog_route.amp_in != 8'h00 |->
      (analog_route.amp_in & ~(ana_in & `GPM_AMP_IN_MASK)) == 8'h00)
    else $error("amp input routed on a wrong pin");

  amp_in_route_a: assert property ( // [R8]
      ana_in[6] && opamp_enable_bit[2] && !chan_pick[6] |->
      analog_route.amp_in[6])
    else $error("unpicked amp input not routed to amp");

  picked_prohibit_a: assert property ( // [R8]
      |(ana_in & `GPM_AMP_IN_MASK & amp_pin_en & chan_pick) |->
      setting_prohibited)
    else $error("picked amp input not flagged");

  analog_cut_a: assert property ( // [R9]
      analog_pin_config_reg != 8'h00 |->
      (analog_pin.oe & analog_pin_config_reg) == 8'h00)
    else $error("analog pin still driven digitally");

  analog_latch_a: assert property ( // [R1]
      wr_en && hit_alatch |=>
      analog_pin.dout == $past(pwdata[7:0]))
    else $error("analog latch write not on pins");

  timer_dir_a: assert property ( // [R11]
      wr_en && hit_tdir |=>
      timer_pin.oe == ~$past(pwdata[4:0]))
    else $error("timer direction write not on enables");

  timer_latch_a: assert property ( // [R19]
      wr_en && hit_tlatch |=>
      timer_port_latch == $past(pwdata[4:0]))
    else $error("timer latch write lost");

  alt_off_a: assert property ( // [R20]
      timer_alt_en == 5'h00 |->
      timer_pin.dout == timer_port_latch)
    else $error("timer pin not from latch");

  debug_port_a: assert property ( // [R15]
      !tool_connected |->
      debug_pin.oe == ~debug_port_direction_reg && debug_pin.dout == debug_port_latch)
    else $error("debug port not driven from its registers");

  debug_pullup_a: assert property ( // [R15]
      debug_pullup_en[1] |->
      debug_port_direction_reg[1] && !debug_pin.oe[1] && !tool_connected)
    else $error("pull-up on a debug pin driven as output");

  tool_sync_a: assert property ( // [R17]
      $past(presetn) && $past(presetn, 2) && $past(clk_en) && $past(clk_en, 2) |->
      tool_data_in == $past(debug_pin_in[0], 2))
    else $error("tool data input not two stages behind pin");
endmodule // gpm_top

/* File: gpm_cfg.svh */
// gpm_cfg.svh: widths, register offsets, reset values and pin masks
// assumes inclusion by the gpio package, the top module, the pad model and the bench
`ifndef GPM_CFG_SVH
`define GPM_CFG_SVH
`define GPM_AW 8
`define GPM_TW 5
`define GPM_DW 2
`define GPM_ADDR_W 12
`define GPM_OFF_ALATCH 12'h000
`define GPM_OFF_ADIR 12'h004
`define GPM_OFF_ACFG 12'h008
`define GPM_OFF_AMPEN 12'h00c
`define GPM_OFF_CHSEL 12'h010
`define GPM_OFF_TLATCH 12'h014
`define GPM_OFF_TDIR 12'h018
`define GPM_OFF_TPU 12'h01c
`define GPM_OFF_DLATCH 12'h020
`define GPM_OFF_DDIR 12'h024
`define GPM_OFF_DPU 12'h028
`define GPM_OFF_STATUS 12'h02c
`define GPM_LATCH_RST_A 8'h00
`define GPM_LATCH_RST_T 5'h00
`define GPM_LATCH_RST_D 2'h0
`define GPM_DIR_RST_A 8'hff
`define GPM_DIR_RST_T 5'h1f
`define GPM_DIR_RST_D 2'h3
`define GPM_CFG_RST 8'h00
`define GPM_PU_RST_T 5'h00
`define GPM_PU_RST_D 2'h0
`define GPM_AMPEN_RST 3'h0
`define GPM_CHSEL_RST 4'h0
`define GPM_AMP_IN_MASK 8'h6d
`define GPM_AMP_OUT_MASK 8'h92
`define GPM_TOOL_DATA_BIT 0
`define GPM_TOOL_CLK_BIT 1
`endif

/* File: gpm_pkg.sv */
// gpm_pkg.sv: pin and routing carrier types of the gpio block
// assumes gpm_cfg.svh is on the include path
package gpm_pkg;
  `include "gpm_cfg.svh"
  typedef struct packed {
    logic [`GPM_AW-1:0] dout;
    logic [`GPM_AW-1:0] oe;
  } gpm_apin_t;
  typedef struct packed {
    logic [`GPM_TW-1:0] dout;
    logic [`GPM_TW-1:0] oe;
  } gpm_tpin_t;
  typedef struct packed {
    logic [`GPM_DW-1:0] dout;
    logic [`GPM_DW-1:0] oe;
  } gpm_dpin_t;
  typedef struct packed {
    logic [`GPM_AW-1:0] convert;
    logic [`GPM_AW-1:0] amp_in;
    logic [`GPM_AW-1:0] amp_out;
  } gpm_ana_t;
endpackage

/* File: gpm_sync.sv */
// gpm_sync.sv: two-flop synchroniser for a group of pin inputs
// assumes pins are asynchronous to pclk; clk_en freezes both stages
`timescale 1ns/1ps
module gpm_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // gpm_sync

/* File: gpm_pins.sv */
// gpm_pins.sv: board and pad model facing the three gpio ports
// assumes one pclk domain; the bench sets external drive values and enables
`timescale 1ns/1ps
`include "gpm_cfg.svh"
module gpm_pins
  import gpm_pkg::*;
(
  // clock
  input wire logic pclk,
  // device side
  input wire gpm_apin_t analog_pin,
  input wire gpm_tpin_t timer_pin,
  input wire logic [`GPM_TW-1:0] timer_pullup_en,
  input wire gpm_dpin_t debug_pin,
  input wire logic [`GPM_DW-1:0] debug_pullup_en,
  // board side
  input wire logic [`GPM_AW-1:0] ext_a,
  input wire logic [`GPM_TW-1:0] ext_t,
  input wire logic [`GPM_TW-1:0] ext_t_oe,
  input wire logic [`GPM_DW-1:0] ext_d,
  input wire logic [`GPM_DW-1:0] ext_d_oe,
  // resolved pin levels
  output logic [`GPM_AW-1:0] analog_pin_in,
  output logic [`GPM_TW-1:0] timer_pin_in,
  output logic [`GPM_DW-1:0] debug_pin_in
);
  // a line nobody drives wobbles, so a missing pull-up never reads as a steady level
  logic wob = 1'b0;
  always @(posedge pclk) wob <= ~wob;
  assign analog_pin_in = (analog_pin.oe & analog_pin.dout) | (~analog_pin.oe & ext_a);
  assign timer_pin_in = (timer_pin.oe & timer_pin.dout) | (~timer_pin.oe & ext_t_oe & ext_t)
    | (~timer_pin.oe & ~ext_t_oe & (timer_pullup_en | {`GPM_TW{wob}}));
  assign debug_pin_in = (debug_pin.oe & debug_pin.dout) | (~debug_pin.oe & ext_d_oe & ext_d)
    | (~debug_pin.oe & ~ext_d_oe & (debug_pullup_en | {`GPM_DW{wob}}));
endmodule // gpm_pins

/* File: test_gpio_ports_analog_mux.sv */
// test_gpio_ports_analog_mux.sv: self-checking bench of the gpio block
// assumes gpm_top with clk_en held high and gpm_pins as the board
`timescale 1ns/1ps
`include "gpm_cfg.svh"
module test_gpio_ports_analog_mux;
  import gpm_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, setting_prohibited, tool_data_in;
  logic [4:0] timer_alt_out = 5'h02, timer_alt_en = 5'h00, ext_t = 5'h00, ext_t_oe = 5'h04;
  logic tool_connected = 1'b0, tool_two_line = 1'b0, tool_data_out = 1'b1;
  logic tool_data_oe = 1'b0, tool_clock_out = 1'b0, tool_clock_oe = 1'b1;
  logic [7:0] ext_a = 8'h5a, a_in;
  logic [4:0] t_in, timer_pullup_en;
  logic [1:0] ext_d = 2'h1, ext_d_oe = 2'h1, d_in, debug_pullup_en;
  gpm_apin_t analog_pin;
  gpm_ana_t analog_route;
  gpm_tpin_t timer_pin;
  gpm_dpin_t debug_pin;
  int n_fail = 0, cmp_count = 0;
  initial forever #12.5 pclk = ~pclk;
  gpm_top u_gpm_top (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_pin_in(a_in), .analog_pin(analog_pin),
    .analog_route(analog_route), .setting_prohibited(setting_prohibited),
    .timer_pin_in(t_in), .timer_alt_out(timer_alt_out), .timer_alt_en(timer_alt_en),
    .timer_pin(timer_pin), .timer_pullup_en(timer_pullup_en), .debug_pin_in(d_in),
    .tool_connected(tool_connected), .tool_two_line(tool_two_line),
    .tool_data_out(tool_data_out), .tool_data_oe(tool_data_oe),
    .tool_clock_out(tool_clock_out), .tool_clock_oe(tool_clock_oe),
    .debug_pin(debug_pin), .debug_pullup_en(debug_pullup_en), .tool_data_in(tool_data_in));
  gpm_pins u_gpm_pins (.pclk(pclk), .analog_pin(analog_pin), .timer_pin(timer_pin),
    .timer_pullup_en(timer_pullup_en), .debug_pin(debug_pin),
    .debug_pullup_en(debug_pullup_en), .ext_a(ext_a), .ext_t(ext_t), .ext_t_oe(ext_t_oe),
    .ext_d(ext_d), .ext_d_oe(ext_d_oe), .analog_pin_in(a_in), .timer_pin_in(t_in),
    .debug_pin_in(d_in));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // pready is watched mid-cycle; the answer is taken at the rising edge that samples it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_fail++;
        report_and_stop();
      end
      @(negedge pclk);
    end
    @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask
  task automatic t_reset;
    chk(32'(analog_pin.oe), 32'h0);
    chk(32'({timer_pin.oe, debug_pin.oe}), 32'h0);
    rdchk(`GPM_OFF_ADIR, 32'hff);
    rdchk(`GPM_OFF_ACFG, 32'h00);
    rdchk(`GPM_OFF_ALATCH, 32'h5a);
    rdchk(`GPM_OFF_TDIR, 32'h1f);
    rdchk(`GPM_OFF_DDIR, 32'h3);
  endtask
  task automatic route_case(input logic [3:0] ch, input logic [23:0] r, input logic p);
    wr(`GPM_OFF_CHSEL, 32'(ch));
    @(negedge pclk);
    chk(32'(analog_route), 32'(r));
    chk(32'(setting_prohibited), 32'(p));
  endtask
  task automatic t_analog;
    wr(`GPM_OFF_ADIR, 32'hf0);
    wr(`GPM_OFF_ALATCH, 32'ha5);
    ext_a <= 8'h3c;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(32'(analog_pin), 32'ha50f);
    rdchk(`GPM_OFF_ALATCH, 32'h35);
    wr(`GPM_OFF_ACFG, 32'hf0);
    wr(`GPM_OFF_AMPEN, 32'h4);
    rdchk(`GPM_OFF_ALATCH, 32'h05);
    route_case(4'h7, 24'h804080, 1'b0);
    route_case(4'h6, 24'h000080, 1'b1);
    route_case(4'h5, 24'h204080, 1'b0);
    route_case(4'h8, 24'h004080, 1'b0);
    wr(`GPM_OFF_AMPEN, 32'h5);
    rdchk(`GPM_OFF_STATUS, 32'h1);
    wr(`GPM_OFF_AMPEN, 32'h4);
    wr(`GPM_OFF_ADIR, 32'he0);
    rdchk(`GPM_OFF_STATUS, 32'h1);
    chk(32'(analog_pin.oe), 32'h0f);
    wr(`GPM_OFF_ADIR, 32'hf0);
  endtask
  task automatic t_timer;
    wr(`GPM_OFF_TDIR, 32'h1c);
    wr(`GPM_OFF_TLATCH, 32'h01);
    wr(`GPM_OFF_TPU, 32'h1f);
    timer_alt_en <= 5'h02;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(32'(timer_pin), 32'h063);
    chk(32'(timer_pullup_en), 32'h1c);
    rdchk(`GPM_OFF_TLATCH, 32'h19);
  endtask
  task automatic t_debug;
    wr(`GPM_OFF_DDIR, 32'h0);
    wr(`GPM_OFF_DLATCH, 32'h2);
    wr(`GPM_OFF_DPU, 32'h3);
    @(negedge pclk);
    chk(32'({debug_pin, debug_pullup_en}), 32'h2c);
    wr(`GPM_OFF_DDIR, 32'h3);
    @(negedge pclk);
    chk(32'({debug_pin, debug_pullup_en}), 32'h23);
    @(posedge pclk);
    tool_connected <= 1'b1;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(32'(debug_pullup_en), 32'h0);
    chk(32'(debug_pin), 32'hc);
    chk(32'(tool_data_in), 32'h1);
    @(posedge pclk);
    tool_two_line <= 1'b1;
    @(negedge pclk);
    chk(32'(debug_pin), 32'h6);
    wr(`GPM_OFF_STATUS, 32'h0);
    rdchk(`GPM_OFF_STATUS, 32'h6);
  endtask
  task automatic t_unmapped;
    logic [31:0] rd;
    logic err;
    apb(1'b1, 12'h030, 32'h0, rd, err);
    chk(32'(err), 32'h1);
    rdchk(`GPM_OFF_ADIR, 32'hf0);
  endtask
  // a second reset in mid-run must undo every programmed direction
  task automatic t_midreset;
    @(posedge pclk);
    presetn <= 1'b0;
    tool_connected <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'({analog_pin.oe, timer_pin.oe, debug_pin.oe}), 32'h0);
    rdchk(`GPM_OFF_ADIR, 32'hff);
    rdchk(`GPM_OFF_ACFG, 32'h00);
    rdchk(`GPM_OFF_TDIR, 32'h1f);
    rdchk(`GPM_OFF_DDIR, 32'h3);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_analog();
    t_timer();
    t_debug();
    t_unmapped();
    t_midreset();
    report_and_stop();
  end
endmodule // test_gpio_ports_analog_mux
